// ===== src/brd_engine.sv
`timescale 1ns/1ns
// What this block does
// - three source channels, one destination channel
// - pointer is two 16-bit words, high first
// - pointer bit zero ignored
// - pointer bits above chip memory ignored
// - four enable bits in control zero
// - disabled channel: no cycle; a, b, c use their preload
// - width low six bits, zero means 64
// - height upper ten bits, zero means 1024
// - writing size starts the blit
// - each word moves pointer by two
// - row end adds signed modulo
// - modulo even, sign-extended before add
// - one word per bus grant only
// - completion sets flag and interrupt
module brd_engine
  import brd_pkg::*;
#(
  parameter int ADDR_W = BRD_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // ****************************************
  // register write port
  // ****************************************
  input wire logic i_reg_wr,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  // ****************************************
  // chip memory port
  // ****************************************
  input wire logic i_bus_grant,
  input wire logic [15:0] i_mem_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic [1:0] o_chan,
  // ****************************************
  // status
  // ****************************************
  output logic o_busy,
  output logic o_done,
  output logic o_irq,
  output logic [15:0] o_op_a,
  output logic [15:0] o_op_b,
  output logic [15:0] o_op_c
);
  if (ADDR_W < 2 || ADDR_W > BRD_PTR_W) begin : g_bad_addr_w
    $error("brd_engine: bad ADDR_W");
  end

  typedef struct packed {
    brd_state_e st;
    logic [3:0] en;
    logic [6:0] width;
    logic [10:0] height;
    logic [6:0] col;
    logic [10:0] row;
    logic [1:0] ch;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic done;
    logic irq;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [15:0] op_c;
    logic busy;
  } brd_eng_s;

  brd_eng_s s_q;
  brd_eng_s s_d;

  logic [ADDR_W-1:0] ch_addr [BRD_NCH];
  logic [15:0] ch_data [BRD_NCH];
  logic [BRD_NCH-1:0] wr_pth;
  logic [BRD_NCH-1:0] wr_ptl;
  logic [BRD_NCH-1:0] wr_mod;
  logic [BRD_NCH-1:0] wr_dat;
  logic [BRD_NCH-1:0] step;
  logic [BRD_NCH-1:0] ld_dat;
  logic row_last;
  logic col_last;
  logic [2:0] nxt_ch;
  logic beat;

  // ****************************************
  // register decode
  // ****************************************
  always_comb begin
    for (int i = 0; i < BRD_NCH; i++) begin
      wr_pth[i] = i_reg_wr && (i_reg_addr == BRD_OFF_PTH_BASE + 5'(2 * i));
      wr_ptl[i] = i_reg_wr && (i_reg_addr == BRD_OFF_PTL_BASE + 5'(2 * i));
      wr_mod[i] = i_reg_wr && (i_reg_addr == BRD_OFF_MOD_BASE + 5'(i));
      wr_dat[i] = i_reg_wr && (i_reg_addr == BRD_OFF_DAT_BASE + 5'(i));
    end
  end

  // ****************************************
  // channels
  // ****************************************
  for (genvar g = 0; g < BRD_NCH; g++) begin : g_ch
    brd_chan #(.ADDR_W(ADDR_W)) u_chan (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_wr_pth(wr_pth[g]),
      .i_wr_ptl(wr_ptl[g]),
      .i_wr_mod(wr_mod[g]),
      .i_wr_dat(wr_dat[g]),
      .i_wdata(i_reg_wdata),
      .i_step(step[g]),
      .i_row_end(col_last),
      .i_ld_dat(ld_dat[g]),
      .i_rdata(i_mem_rdata),
      .o_addr(ch_addr[g]),
      .o_data(ch_data[g])
    );
  end

  // ****************************************
  // sequencer
  // ****************************************
  // first enabled channel after the current one, in order a, b, c, d
  function automatic logic [2:0] next_en(input logic [3:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h4;
    for (int k = 3; k >= 0; k--) begin
      if (en[k] && 3'(k) >= from) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction : next_en

  assign beat = s_q.req && i_bus_grant;
  assign col_last = (s_q.col == s_q.width);
  assign row_last = (s_q.row == s_q.height);

  always_comb begin
    s_d = s_q;
    step = '0;
    ld_dat = '0;
    nxt_ch = 3'h4;
    case (s_q.st)
      BRD_IDLE: begin
        s_d.req = 1'b0;
      end
      BRD_XFER: begin
        // one word per grant; the request holds until the bus is ours
        if (beat) begin
          step[s_q.ch] = 1'b1;
          ld_dat[s_q.ch] = !s_q.we;
          if (s_q.ch == BRD_CH_A) begin
            s_d.op_a = i_mem_rdata;
          end else if (s_q.ch == BRD_CH_B) begin
            s_d.op_b = i_mem_rdata;
          end else if (s_q.ch == BRD_CH_C) begin
            s_d.op_c = i_mem_rdata;
          end
          s_d.req = 1'b0;
          s_d.st = BRD_ROW;
        end
      end
      BRD_ROW: begin
        nxt_ch = next_en(s_q.en, 3'(s_q.ch) + 3'h1);
        if (nxt_ch == 3'h4) begin
          // word slot finished for all enabled channels
          nxt_ch = next_en(s_q.en, 3'h0);
          if (col_last) begin
            s_d.col = 7'h01;
            if (row_last) begin
              nxt_ch = 3'h4;
            end else begin
              s_d.row = s_q.row + 11'h001;
            end
          end else begin
            s_d.col = s_q.col + 7'h01;
          end
        end
        if (nxt_ch == 3'h4) begin
          s_d.st = BRD_IDLE;
          s_d.done = 1'b1;
          s_d.irq = 1'b1;
        end else begin
          s_d.ch = nxt_ch[1:0];
          s_d.we = (nxt_ch[1:0] == BRD_CH_D);
          s_d.st = BRD_XFER;
          s_d.req = 1'b1;
        end
      end
      default: begin
        s_d.st = BRD_IDLE;
      end
    endcase
    if (s_q.st == BRD_XFER || s_q.st == BRD_ROW) begin
      s_d.addr = ch_addr[s_d.ch];
    end
    // destination carries the a operand; logic function lives elsewhere
    // tracked every cycle so a blit that opens on channel d stores fresh data
    s_d.wdata = s_q.op_a;
    s_d.irq = s_d.irq && !(s_q.irq);
    // disabled sources present their preload every cycle
    if (!s_q.en[0] && !ld_dat[0]) begin
      s_d.op_a = wr_dat[0] ? i_reg_wdata : ch_data[0];
    end
    if (!s_q.en[1] && !ld_dat[1]) begin
      s_d.op_b = wr_dat[1] ? i_reg_wdata : ch_data[1];
    end
    if (!s_q.en[2] && !ld_dat[2]) begin
      s_d.op_c = wr_dat[2] ? i_reg_wdata : ch_data[2];
    end
    if (i_reg_wr && i_reg_addr == BRD_OFF_CTRL0) begin
      s_d.en[0] = i_reg_wdata[BRD_EN_A_BIT];
      s_d.en[1] = i_reg_wdata[BRD_EN_B_BIT];
      s_d.en[2] = i_reg_wdata[BRD_EN_C_BIT];
      s_d.en[3] = i_reg_wdata[BRD_EN_D_BIT];
    end
    // a size write during a blit is ignored; restart would corrupt pointers
    if (i_reg_wr && i_reg_addr == BRD_OFF_SIZE && s_q.st == BRD_IDLE) begin
      s_d.width = {(i_reg_wdata[BRD_WIDTH_LSB +: BRD_WIDTH_W] == 6'h00),
                   i_reg_wdata[BRD_WIDTH_LSB +: BRD_WIDTH_W]};
      s_d.height = {(i_reg_wdata[BRD_HEIGHT_LSB +: BRD_HEIGHT_W] == 10'h000),
                    i_reg_wdata[BRD_HEIGHT_LSB +: BRD_HEIGHT_W]};
      s_d.col = 7'h01;
      s_d.row = 11'h001;
      s_d.done = 1'b0;
      nxt_ch = next_en(s_d.en, 3'h0);
      if (nxt_ch == 3'h4) begin
        // no enabled channel: nothing to move, finish at once
        s_d.done = 1'b1;
        s_d.irq = 1'b1;
      end else begin
        s_d.ch = nxt_ch[1:0];
        s_d.we = (nxt_ch[1:0] == BRD_CH_D);
        s_d.addr = ch_addr[nxt_ch[1:0]];
        s_d.st = BRD_XFER;
        s_d.req = 1'b1;
      end
    end
    // busy is its own flop so the status output comes straight from a register
    s_d.busy = (s_d.st != BRD_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '{st: BRD_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_mem_req = s_q.req;
  assign o_mem_we = s_q.we;
  assign o_mem_addr = s_q.addr;
  assign o_mem_wdata = s_q.wdata;
  assign o_chan = s_q.ch;
  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_irq = s_q.irq;
  assign o_op_a = s_q.op_a;
  assign o_op_b = s_q.op_b;
  assign o_op_c = s_q.op_c;
endmodule : brd_engine

// ===== src/brd_pkg.sv
package brd_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int BRD_ADDR_W = 19;
  localparam int BRD_PTR_W = 32;
  // ****************************************
  // register word offsets (word index on the register port)
  // ****************************************
  localparam logic [4:0] BRD_OFF_CTRL0 = 5'h00;
  localparam logic [4:0] BRD_OFF_SIZE = 5'h01;
  localparam logic [4:0] BRD_OFF_PTH_BASE = 5'h08;
  localparam logic [4:0] BRD_OFF_PTL_BASE = 5'h09;
  localparam logic [4:0] BRD_OFF_MOD_BASE = 5'h10;
  localparam logic [4:0] BRD_OFF_DAT_BASE = 5'h14;
  // ****************************************
  // control register zero fields
  // ****************************************
  localparam int BRD_EN_A_BIT = 11;
  localparam int BRD_EN_B_BIT = 10;
  localparam int BRD_EN_C_BIT = 9;
  localparam int BRD_EN_D_BIT = 8;
  // ****************************************
  // size register fields
  // ****************************************
  localparam int BRD_WIDTH_LSB = 0;
  localparam int BRD_WIDTH_W = 6;
  localparam int BRD_HEIGHT_LSB = 6;
  localparam int BRD_HEIGHT_W = 10;
  // ****************************************
  // reset values and step
  // ****************************************
  localparam logic [15:0] BRD_RST_WORD = 16'h0000;
  localparam logic [BRD_ADDR_W-1:0] BRD_WORD_STEP = 19'h00002;
  localparam int BRD_NCH = 4;
  localparam logic [1:0] BRD_CH_A = 2'h0;
  localparam logic [1:0] BRD_CH_B = 2'h1;
  localparam logic [1:0] BRD_CH_C = 2'h2;
  localparam logic [1:0] BRD_CH_D = 2'h3;

  typedef enum logic [1:0] {
    BRD_IDLE = 2'b00,
    BRD_XFER = 2'b01,
    BRD_ROW = 2'b10
  } brd_state_e;
endpackage : brd_pkg

// ===== src/brd_chan.sv
`timescale 1ns/1ns
// one channel's pointer, modulo and data
module brd_chan
  import brd_pkg::*;
#(
  parameter int ADDR_W = BRD_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_pth,
  input wire logic i_wr_ptl,
  input wire logic i_wr_mod,
  input wire logic i_wr_dat,
  input wire logic [15:0] i_wdata,
  input wire logic i_step,
  input wire logic i_row_end,
  input wire logic i_ld_dat,
  input wire logic [15:0] i_rdata,
  output logic [ADDR_W-1:0] o_addr,
  output logic [15:0] o_data
);
  if (ADDR_W < 2 || ADDR_W > BRD_PTR_W) begin : g_bad_addr_w
    $error("brd_chan: bad ADDR_W");
  end

  typedef struct packed {
    logic [BRD_PTR_W-1:0] ptr;
    logic [15:0] modv;
    logic [15:0] dat;
  } brd_chan_s;

  brd_chan_s st_q;
  brd_chan_s st_d;
  logic [ADDR_W-1:0] ptr_w;
  logic [ADDR_W-1:0] mod_ext;

  always_comb begin
    // only the chip memory range is kept, bit zero dropped
    ptr_w = {st_q.ptr[ADDR_W-1:1], 1'b0};
    // sign-extend modulo with bit zero forced even
    mod_ext = ADDR_W'({{(BRD_PTR_W-16){st_q.modv[15]}}, st_q.modv[15:1], 1'b0});
    st_d = st_q;
    if (i_wr_pth) begin
      st_d.ptr[31:16] = i_wdata;
    end
    if (i_wr_ptl) begin
      st_d.ptr[15:0] = i_wdata;
    end
    if (i_wr_mod) begin
      st_d.modv = i_wdata;
    end
    if (i_wr_dat) begin
      st_d.dat = i_wdata;
    end else if (i_ld_dat) begin
      st_d.dat = i_rdata;
    end
    if (i_step) begin
      if (i_row_end) begin
        st_d.ptr[ADDR_W-1:0] = ptr_w + ADDR_W'(BRD_WORD_STEP) + mod_ext;
      end else begin
        st_d.ptr[ADDR_W-1:0] = ptr_w + ADDR_W'(BRD_WORD_STEP);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_addr = ptr_w;
  assign o_data = st_q.dat;
endmodule : brd_chan

// ===== bench/brd_props.sv
`timescale 1ns/1ns
module brd_props
  import brd_pkg::*;
#(
  parameter int ADDR_W = BRD_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_bus_grant,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic [1:0] o_chan,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_irq,
  input wire logic [15:0] o_op_a
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ****
  // memory port
  // ****
  property p_even; o_mem_req |-> !o_mem_addr[0]; endproperty
  a_even: assert property (p_even) else $error("odd address");
  property p_hold;
    o_mem_req && !i_bus_grant |=> o_mem_req && $stable(o_mem_addr) && $stable(o_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_gap; o_mem_req && i_bus_grant |=> !o_mem_req; endproperty
  a_gap: assert property (p_gap) else $error("two words per grant");
  property p_dir; o_mem_req |-> o_mem_we == (o_chan == BRD_CH_D); endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_wdata; o_mem_req && o_mem_we |-> o_mem_wdata == o_op_a; endproperty
  a_wdata: assert property (p_wdata) else $error("store data");
  // ****
  // control and completion
  // ****
  property p_start;
    i_reg_wr && i_reg_addr == BRD_OFF_SIZE && !o_busy |=> o_busy || o_done;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_idle; !o_busy |-> !o_mem_req; endproperty
  a_idle: assert property (p_idle) else $error("request while idle");
  property p_pulse; o_irq |=> !o_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("long irq");
  property p_flag; o_irq |-> o_done && !o_busy; endproperty
  a_flag: assert property (p_flag) else $error("irq without flag");
endmodule : brd_props
bind brd_engine brd_props #(.ADDR_W(ADDR_W)) u_props (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr),
  .i_bus_grant(i_bus_grant),
  .o_mem_req(o_mem_req),
  .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata),
  .o_chan(o_chan),
  .o_busy(o_busy),
  .o_done(o_done),
  .o_irq(o_irq),
  .o_op_a(o_op_a)
);

// ===== bench/brd_mem_model.sv
`timescale 1ns/1ns
module brd_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [18:0] i_addr,
  output logic o_grant,
  output logic [15:0] o_rdata
);
  logic [1:0] cnt_q = 2'h0;
  logic [15:0] last_q = 16'h0;
  logic hit;
  always @(posedge i_clk) begin
    cnt_q <= cnt_q + 2'h1;
    if (hit) begin
      last_q <= o_rdata;
    end
  end
  // slow mode offers the bus one cycle in four
  assign o_grant = !i_slow || cnt_q == 2'h3;
  assign hit = i_req && o_grant && !i_we;
  // a released line shows the inverse of the last word, never a stale copy
  assign o_rdata = hit ? (i_addr[15:0] ^ 16'h5a5a) : ~last_q;
endmodule : brd_mem_model

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  import brd_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, i_reg_wr = 0, slow = 0, i_bus_grant;
  logic [4:0] i_reg_addr = 5'h00;
  logic [15:0] i_reg_wdata = 16'h0000, i_mem_rdata, o_mem_wdata, o_op_a, o_op_b, o_op_c;
  logic o_mem_req, o_mem_we, o_busy, o_done, o_irq;
  logic [BRD_ADDR_W-1:0] o_mem_addr;
  logic [1:0] o_chan;
  int miscompares = 0, n_tests = 0;
  logic [37:0] got[$];
  logic [31:0] ptr[4];
  logic [15:0] md[4], dat[4];
  initial forever #4 i_clk = ~i_clk;
  brd_engine dut (.*);
  brd_mem_model mem (.i_clk(i_clk), .i_slow(slow), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .o_grant(i_bus_grant), .o_rdata(i_mem_rdata));
  always @(posedge i_clk) begin
    if (o_mem_req && i_bus_grant) begin
      got.push_back({o_mem_we ? o_mem_wdata : 16'h0, o_chan, o_mem_we, o_mem_addr});
    end
  end
  // ****
  // helpers
  // ****
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_reg_wr = 1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 0;
  endtask : wr
  // en bit 0..3 = channels a..d
  task automatic blit(input logic [3:0] en, input logic [5:0] w, input logic [9:0] h);
    logic [18:0] p[4];
    logic [15:0] a;
    int nw, nh, k;
    nw = (w == 0) ? 64 : int'(w);
    nh = (h == 0) ? 1024 : int'(h);
    got.delete();
    wr(BRD_OFF_CTRL0, {4'h0, en[0], en[1], en[2], en[3], 8'h00});
    for (int i = 0; i < 4; i++) begin
      wr(BRD_OFF_PTH_BASE + 5'(2 * i), ptr[i][31:16]);
      wr(BRD_OFF_PTL_BASE + 5'(2 * i), ptr[i][15:0]);
      wr(BRD_OFF_MOD_BASE + 5'(i), md[i]);
      wr(BRD_OFF_DAT_BASE + 5'(i), dat[i]);
      p[i] = {ptr[i][18:1], 1'b0};
    end
    wr(BRD_OFF_SIZE, {h, w});
    k = 0;
    while (o_done !== 1'b1 && k < 20000) begin
      @(negedge i_clk);
      k++;
    end
    chk({o_done, o_irq, o_busy}, 48'h6);
    a = dat[0];
    for (int r = 0; r < nh; r++) begin
      for (int c = 0; c < nw; c++) begin
        for (int i = 0; i < 4; i++) begin
          if (en[i]) begin
            if (i == 0) begin
              a = p[0][15:0] ^ 16'h5a5a;
            end
            chk(got.pop_front(), {(i == 3) ? a : 16'h0, 2'(i), i == 3, p[i]});
            p[i] += 19'h2;
          end
        end
      end
      for (int i = 0; i < 4; i++) begin
        p[i] += {{3{md[i][15]}}, md[i][15:1], 1'b0};
      end
    end
    chk(48'(got.size()), 48'h0);
  endtask : blit
  // ****
  // scenarios
  // ****
  task automatic t_copy;
    slow = 1;
    ptr = '{32'hfff8_1235, 32'h0, 32'h0, 32'h0004_0101};
    md = '{16'h0003, 16'h0, 16'h0, 16'hfff9};
    blit(4'b1001, 6'h03, 10'h002);
  endtask : t_copy
  task automatic t_wide;
    slow = 0;
    ptr = '{32'h0, 32'h0000_2000, 32'h0, 32'h0};
    dat = '{16'h1357, 16'h0, 16'h2468, 16'h0};
    blit(4'b0010, 6'h00, 10'h001);
    chk({o_op_a, o_op_c}, {16'h0, dat[0], dat[2]});
    chk(o_op_b, 16'h207e ^ 16'h5a5a);
  endtask : t_wide
  task automatic t_tall;
    ptr = '{32'h0, 32'h0, 32'h0000_4000, 32'h0006_0000};
    md = '{16'h0, 16'h0, 16'h0002, 16'hfffe};
    blit(4'b1100, 6'h01, 10'h000);
  endtask : t_tall
  task automatic final_report;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
  initial begin
    dat = '{16'h0, 16'h0, 16'h0, 16'h0};
    repeat (12) @(negedge i_clk);
    i_sys_rst = 0;
    chk({o_mem_req, o_busy, o_done, o_irq}, 48'h0);
    t_copy();
    t_wide();
    t_tall();
    final_report();
  end
endmodule : tb
